/* File: verilog/scl_device.sv */
// Display end: rate-locking UART, command FIFO and reply engine
`include "scl_consts.svh"
// Contract
// - Eight data bits, no parity, one stop
// - Start bit low, stop high, idle high
// - Data bits go least significant first
// - Works at any rate 300 to 256K
// - Receive and transmit at the same time
// - Every finished command gets a reply
// - Success without reply data sends 06
// - Failure without reply data sends 15
// - Unknown command code answered with 15
// - Framing by byte position only
// - Reply length and delay vary per command
// - Reset low over 2 us resets fully
// - Host drives reset open drain only
// - Reports which of five buttons active
// - Button grounded at start runs script
// - First byte 55 locks rate, then ACK
// - Host waits out settle time after reset
// - Host holds its line high early
// - No lock in 5 s shows splash, except while the script runs
module scl_device #(
  parameter int SPLASH_CYC = `SCL_SPLASH_CYC,
  parameter int DEPTH = `SCL_FIFO_DEPTH
) (
  // Clock
  input wire logic sys_clk,
  // Serial link and reset wire
  scl_link_if.device link,
  // Button ladder result and startup strap
  input wire logic [4:0] button_state,
  input wire logic button_grounded,
  // Status to the display side
  output logic locked,
  output logic splash_show,
  output logic script_run,
  output logic rx_frame_err
);
  import scl_pkg::*;
  localparam int BW = 20;
  initial begin
    if (SPLASH_CYC < 1 || DEPTH < 2) $error("scl_device parameters out of range");
  end
  logic rst_n;
  assign rst_n = link.reset_line_n;
  typedef struct packed {
    scl_rx_e rx;
    logic [BW-1:0] bit_cyc;
    logic [BW-1:0] rcnt;
    logic [2:0] ridx;
    logic [7:0] rsh;
    logic rpush;
    logic [7:0] rbyte;
    logic ferr;
    logic measuring;
    logic locked;
    logic [31:0] splash_cnt;
    logic splash;
    logic strap_done;
    logic script;
    scl_cmd_e cmd;
    logic [7:0] reply;
    logic [7:0] reply2;
    logic tx_busy;
    logic [BW-1:0] tcnt;
    logic [3:0] tidx;
    logic [9:0] tsh;
    logic txd;
  } scl_dev_s;
  scl_dev_s st_q, st_d;
  logic f_valid, f_ready, f_in_ready;
  logic [7:0] f_data;
  // Received bytes queued so a slow reply engine stalls cleanly
  scl_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(st_q.rpush),
    .in_ready(f_in_ready),
    .in_data(st_q.rbyte),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  function automatic logic [2:0] button_code(input logic [4:0] b);
    button_code = 3'd0;
    for (int i = 4; i >= 0; i--) begin
      if (b[i]) button_code = 3'(i + 1);
    end
  endfunction
  // Lock byte is drained too, so it never reaches the command decoder
  assign f_ready = (st_q.cmd == SCL_IDLE) || (st_q.cmd == SCL_WAIT_LOCK);
  always_comb begin
    st_d = st_q;
    st_d.rpush = 1'b0;
    // Receiver: bit period learned from the lock byte start bit
    case (st_q.rx)
      SCL_RX_IDLE: begin
        if (!link.host_to_dev) begin
          st_d.rx = SCL_RX_START;
          st_d.rcnt = '0;
          st_d.measuring = !st_q.locked;
        end
      end
      SCL_RX_START: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        if (st_q.measuring) begin
          if (link.host_to_dev) begin
            // 55 starts with one low start bit then a high bit 0
            st_d.bit_cyc = st_q.rcnt + 1'b1;
            st_d.rcnt = BW'(1);
            st_d.rx = SCL_RX_DATA;
            st_d.ridx = '0;
          end
        end else if (st_q.rcnt == (st_q.bit_cyc >> 1)) begin
          st_d.rcnt = '0;
          st_d.ridx = '0;
          st_d.rx = link.host_to_dev ? SCL_RX_IDLE : SCL_RX_DATA;
        end
      end
      SCL_RX_DATA: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        // Whole bit periods from mid-bit, so no drift builds up over a byte
        if (st_q.rcnt == ((st_q.measuring && st_q.ridx == 3'd0) ?
            (st_q.bit_cyc >> 1) : (st_q.bit_cyc - 1'b1))) begin
          st_d.rcnt = '0;
          st_d.rsh = {link.host_to_dev, st_q.rsh[7:1]};
          st_d.ridx = st_q.ridx + 1'b1;
          if (st_q.ridx == 3'd7) st_d.rx = SCL_RX_STOP;
        end
      end
      SCL_RX_STOP: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        if (st_q.rcnt == st_q.bit_cyc - 1'b1) begin
          st_d.rx = SCL_RX_IDLE;
          st_d.measuring = 1'b0;
          if (link.host_to_dev && f_in_ready) begin
            st_d.rpush = 1'b1;
            st_d.rbyte = st_q.rsh;
          end else begin
            st_d.ferr = 1'b1; // Sticky: bad stop bit or full buffer
          end
        end
      end
      default: st_d.rx = SCL_RX_IDLE;
    endcase
    // Strap caught once after reset release
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.script = button_grounded;
    end
    // Splash timeout while no lock byte seen and no script running
    if (!st_q.locked && !st_q.splash && !st_q.script) begin
      st_d.splash_cnt = st_q.splash_cnt + 1'b1;
      if (st_q.splash_cnt == 32'(SPLASH_CYC - 1)) st_d.splash = 1'b1;
    end
    // Command engine, one byte position at a time
    case (st_q.cmd)
      SCL_WAIT_LOCK: begin
        if (f_valid) begin
          st_d.locked = 1'b1;
          st_d.reply = `SCL_BYTE_ACK;
          st_d.reply2 = '0;
          st_d.cmd = SCL_REPLY;
        end
      end
      SCL_IDLE: begin
        if (f_valid) st_d.cmd = SCL_EXEC;
        if (f_valid) st_d.reply2 = f_data;
      end
      SCL_EXEC: begin
        st_d.cmd = SCL_REPLY;
        case (st_q.reply2)
          `SCL_CMD_NOP: st_d.reply = `SCL_BYTE_ACK;
          `SCL_CMD_FAIL: st_d.reply = `SCL_BYTE_NAK;
          `SCL_CMD_BUTTONS: st_d.reply = {5'h00, button_code(button_state)};
          default: st_d.reply = `SCL_BYTE_NAK;
        endcase
        st_d.reply2 = (st_q.reply2 == `SCL_CMD_BUTTONS) ? `SCL_BYTE_ACK : 8'h00;
      end
      SCL_REPLY, SCL_REPLY2: begin
        if (!st_q.tx_busy) begin
          st_d.tx_busy = 1'b1;
          st_d.tsh = {1'b1, st_q.reply, 1'b0};
          st_d.tidx = '0;
          st_d.tcnt = '0;
          if (st_q.cmd == SCL_REPLY && st_q.reply2 != 8'h00 && st_q.locked &&
              st_q.reply != `SCL_BYTE_ACK) begin
            st_d.reply = st_q.reply2;
            st_d.cmd = SCL_REPLY2;
          end else begin
            st_d.cmd = SCL_IDLE;
          end
        end
      end
      default: st_d.cmd = SCL_WAIT_LOCK;
    endcase
    // Transmitter runs independently of the receiver
    if (st_q.tx_busy) begin
      st_d.txd = st_q.tsh[0];
      st_d.tcnt = st_q.tcnt + 1'b1;
      if (st_q.tcnt == st_q.bit_cyc - 1'b1) begin
        st_d.tcnt = '0;
        st_d.tsh = {1'b1, st_q.tsh[9:1]};
        st_d.tidx = st_q.tidx + 1'b1;
        if (st_q.tidx == 4'd9) begin
          st_d.tx_busy = 1'b0;
          st_d.txd = 1'b1;
        end
      end
    end else begin
      st_d.txd = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.txd <= 1'b1;
      st_q.bit_cyc <= BW'(1);
    end else begin
      st_q <= st_d;
    end
  end
  assign link.dev_to_host = st_q.txd;
  assign locked = st_q.locked;
  assign splash_show = st_q.splash;
  assign script_run = st_q.script;
  assign rx_frame_err = st_q.ferr;
endmodule

/* File: common/scl_consts.svh */
// Constants of the serial command link: framing, reply codes and timing
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH
`define SCL_CLK_HZ 200000000
`define SCL_DATA_BITS 8
`define SCL_BYTE_ACK 8'h06
`define SCL_BYTE_NAK 8'h15
`define SCL_BYTE_LOCK 8'h55
`define SCL_RATE_MIN 300
`define SCL_RATE_MAX 256000
`define SCL_RST_MIN_NS 2000
`define SCL_RST_MIN_CYC ((`SCL_RST_MIN_NS * 200 + 999) / 1000)
`define SCL_SPLASH_MS 5000
`define SCL_SPLASH_CYC (`SCL_SPLASH_MS * 200000)
`define SCL_SETTLE_MS 500
`define SCL_SETTLE_CYC (`SCL_SETTLE_MS * 200000)
`define SCL_CMD_NOP 8'h01
`define SCL_CMD_BUTTONS 8'h6a
`define SCL_CMD_FAIL 8'h02
`define SCL_FIFO_DEPTH 32
`endif

/* File: common/scl_pkg.sv */
// Types shared by both ends of the serial command link
package scl_pkg;
  typedef logic [7:0] scl_byte_t;
  typedef enum logic [2:0] {
    SCL_WAIT_LOCK = 3'b000,
    SCL_IDLE      = 3'b001,
    SCL_EXEC      = 3'b011,
    SCL_REPLY     = 3'b010,
    SCL_REPLY2    = 3'b110
  } scl_cmd_e;
  typedef enum logic [1:0] {
    SCL_RX_IDLE  = 2'b00,
    SCL_RX_START = 2'b01,
    SCL_RX_DATA  = 2'b11,
    SCL_RX_STOP  = 2'b10
  } scl_rx_e;
endpackage

/* File: common/scl_link_if.sv */
// Serial lines and reset wire joining host and display ends
interface scl_link_if;
  logic host_to_dev;
  logic dev_to_host;
  logic reset_pull_oe;
  logic reset_line_n;
  assign reset_line_n = ~reset_pull_oe;
  modport device (input host_to_dev, output dev_to_host, input reset_line_n);
  modport host (output host_to_dev, input dev_to_host, output reset_pull_oe);
endinterface

/* File: verilog/scl_fifo.sv */
// Parameterised valid/ready FIFO holding received command bytes
module scl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("scl_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } scl_fifo_s;
  scl_fifo_s st_q, st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;
  // Full when pointers differ only in the wrap bit
  assign in_ready = !((st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]));
  assign out_valid = st_q.wr != st_q.rd;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[st_q.rd[AW-1:0]];
  // Pointer update
  always_comb begin
    st_d = st_q;
    if (push) st_d.wr = st_q.wr + 1'b1;
    if (pop) st_d.rd = st_q.rd + 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) st_q <= '0;
    else st_q <= st_d;
  end
  // Storage kept out of reset to stay a plain memory
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[st_q.wr[AW-1:0]] <= in_data;
  end
endmodule

/* File: verilog/scl_host.sv */
// Host end: resets the display, locks its rate, sends commands
`include "scl_consts.svh"
module scl_host #(
  parameter int BIT_CYC = 800,
  parameter int SETTLE_CYC = `SCL_SETTLE_CYC
) (
  // Clock and local reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link and reset wire
  scl_link_if.host link,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  // Reply bytes
  output logic reply_valid,
  output logic [7:0] reply_byte
);
  import scl_pkg::*;
  initial begin
    if (BIT_CYC < 4 || BIT_CYC > 65536 || SETTLE_CYC < 1) begin
      $error("scl_host parameters out of range");
    end
  end
  typedef struct packed {
    logic [1:0] phase;
    logic [31:0] cnt;
    logic tx_busy;
    logic [15:0] tcnt;
    logic [3:0] tidx;
    logic [9:0] tsh;
    logic txd;
    logic await;
    scl_rx_e rx;
    logic [15:0] rcnt;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic rv;
    logic [7:0] rb;
  } scl_host_s;
  scl_host_s st_q, st_d;
  // Ready only when locked, idle and not awaiting a reply
  assign cmd_ready = st_q.phase == 2'd3 && !st_q.tx_busy && !st_q.await;
  always_comb begin
    st_d = st_q;
    st_d.rv = 1'b0;
    case (st_q.phase)
      2'd0: begin
        st_d.cnt = st_q.cnt + 1'b1;
        if (st_q.cnt == 32'(`SCL_RST_MIN_CYC)) begin
          st_d.phase = 2'd1;
          st_d.cnt = '0;
        end
      end
      2'd1: begin
        st_d.cnt = st_q.cnt + 1'b1;
        if (st_q.cnt == 32'(SETTLE_CYC - 1)) begin
          st_d.phase = 2'd2;
          st_d.tx_busy = 1'b1;
          st_d.tsh = {1'b1, `SCL_BYTE_LOCK, 1'b0};
          st_d.tcnt = '0;
          st_d.tidx = '0;
          st_d.await = 1'b1;
        end
      end
      2'd2: if (st_q.rv) st_d.phase = 2'd3;
      default: begin
        if (cmd_valid && cmd_ready) begin
          st_d.tx_busy = 1'b1;
          st_d.tsh = {1'b1, cmd_byte, 1'b0};
          st_d.tcnt = '0;
          st_d.tidx = '0;
          st_d.await = cmd_last;
        end
      end
    endcase
    if (st_q.tx_busy) begin
      st_d.txd = st_q.tsh[0];
      st_d.tcnt = st_q.tcnt + 1'b1;
      if (st_q.tcnt == 16'(BIT_CYC - 1)) begin
        st_d.tcnt = '0;
        st_d.tsh = {1'b1, st_q.tsh[9:1]};
        st_d.tidx = st_q.tidx + 1'b1;
        if (st_q.tidx == 4'd9) st_d.tx_busy = 1'b0;
      end
    end else begin
      st_d.txd = 1'b1;
    end
    // Receiver ignores the line until settle time has passed
    case (st_q.rx)
      SCL_RX_IDLE: begin
        if (!link.dev_to_host && st_q.phase >= 2'd2) begin
          st_d.rx = SCL_RX_START;
          st_d.rcnt = '0;
        end
      end
      SCL_RX_START: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        if (st_q.rcnt == 16'(BIT_CYC / 2)) begin
          st_d.rcnt = '0;
          st_d.ridx = '0;
          st_d.rx = link.dev_to_host ? SCL_RX_IDLE : SCL_RX_DATA;
        end
      end
      SCL_RX_DATA: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        if (st_q.rcnt == 16'(BIT_CYC - 1)) begin
          st_d.rcnt = '0;
          st_d.rsh = {link.dev_to_host, st_q.rsh[7:1]};
          st_d.ridx = st_q.ridx + 1'b1;
          if (st_q.ridx == 4'd7) st_d.rx = SCL_RX_STOP;
        end
      end
      SCL_RX_STOP: begin
        st_d.rcnt = st_q.rcnt + 1'b1;
        if (st_q.rcnt == 16'(BIT_CYC - 1)) begin
          st_d.rx = SCL_RX_IDLE;
          if (link.dev_to_host) begin
            st_d.rv = 1'b1;
            st_d.rb = st_q.rsh;
            st_d.await = 1'b0;
          end
        end
      end
      default: st_d.rx = SCL_RX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.txd <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
  assign link.reset_pull_oe = st_q.phase == 2'd0;
  assign link.host_to_dev = st_q.txd;
  assign reply_valid = st_q.rv;
  assign reply_byte = st_q.rb;
endmodule

/* File: verification/scl_link_assertions.sv */
// Checker on the serial wires and reset wire between the two ends
`include "scl_consts.svh"
module scl_link_assertions #(
  parameter int BIT_CYC = 40
) (
  // Clock and host reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Interface signals
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic reset_pull_oe,
  input wire logic reset_line_n
);
  // The device measures its own bit time, so allow an eighth of a bit
  localparam int TOL = BIT_CYC / 8;
  localparam int RUN_MIN = BIT_CYC - TOL;
  localparam int RUN_MAX = 9 * (BIT_CYC + TOL);
  localparam int BIT_MAX = BIT_CYC + TOL;
  localparam int RST_MIN = `SCL_RST_MIN_CYC;
  logic h_last_q, d_last_q, h_chg, d_chg;
  logic [15:0] h_run_q, d_run_q, r_run_q;
  logic [3:0] h_edge_q;
  default clocking cb @(posedge sys_clk); endclocking
  assign h_chg = host_to_dev != h_last_q;
  assign d_chg = dev_to_host != d_last_q;
  // Run lengths of each line level and of the reset pull, saturating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_last_q <= 1'b1;
      d_last_q <= 1'b1;
      h_run_q <= 16'h0000;
      d_run_q <= 16'h0000;
      r_run_q <= 16'h0000;
      h_edge_q <= 4'h0;
    end else begin
      h_last_q <= host_to_dev;
      d_last_q <= dev_to_host;
      h_run_q <= h_chg ? 16'h0001 : h_run_q + {15'h0000, ~&h_run_q};
      d_run_q <= d_chg ? 16'h0001 : d_run_q + {15'h0000, ~&d_run_q};
      r_run_q <= reset_pull_oe ? r_run_q + {15'h0000, ~&r_run_q} : 16'h0000;
      h_edge_q <= h_edge_q + {3'h0, h_chg & ~&h_edge_q};
    end
  end
  // Edges inside the first frame, which must alternate every bit
  sequence s_lock_edge;
    h_chg && h_edge_q != 4'h0 && h_edge_q < 4'ha;
  endsequence
  property p_reset_wire;
    disable iff (!rst_n) reset_line_n == !reset_pull_oe;
  endproperty
  property p_reset_width;
    disable iff (!rst_n) $fell(reset_pull_oe) |-> r_run_q >= RST_MIN;
  endproperty
  property p_dev_idle_reset;
    disable iff (!rst_n) !reset_line_n |-> dev_to_host;
  endproperty
  property p_h_min;
    disable iff (!rst_n) h_chg |-> h_run_q >= RUN_MIN;
  endproperty
  property p_h_max;
    disable iff (!rst_n) (h_chg && host_to_dev) |-> h_run_q <= RUN_MAX;
  endproperty
  property p_d_min;
    disable iff (!rst_n || !reset_line_n) d_chg |-> d_run_q >= RUN_MIN;
  endproperty
  property p_d_max;
    disable iff (!rst_n || !reset_line_n) (d_chg && dev_to_host) |-> d_run_q <= RUN_MAX;
  endproperty
  property p_lock_bits;
    disable iff (!rst_n) s_lock_edge |-> h_run_q <= BIT_MAX;
  endproperty
  a_reset_wire: assert property (p_reset_wire) else $error("reset wire level wrong");
  a_reset_width: assert property (p_reset_width) else $error("reset pulse short");
  a_dev_idle_reset: assert property (p_dev_idle_reset) else $error("tx low in reset");
  a_h_min: assert property (p_h_min) else $error("host bit too short");
  a_h_max: assert property (p_h_max) else $error("host low too long");
  a_d_min: assert property (p_d_min) else $error("device bit too short");
  a_d_max: assert property (p_d_max) else $error("device low too long");
  a_lock_bits: assert property (p_lock_bits) else $error("first frame wrong");
endmodule

/* File: verification/tb_serial_command_link.sv */
// Self-checking bench joining host and display ends over the link
`include "scl_consts.svh"
module tb_serial_command_link;
  timeunit 1ns;
  timeprecision 1ps;
  import scl_pkg::*;
  localparam int BIT_CYC = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_last = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic [4:0] button_state = 5'h00;
  logic button_grounded = 1'b0;
  logic cmd_ready, reply_valid, locked, splash_show, script_run, rx_frame_err;
  logic [7:0] reply_byte;
  logic armed = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int btn_k = 0;
  scl_byte_t exp_q[$], wire_q[$];
  scl_link_if u_scl_link_if();
  always #2.5 sys_clk = ~sys_clk;
  scl_device #(.SPLASH_CYC(2000)) u_scl_device (.sys_clk(sys_clk),
    .link(u_scl_link_if), .button_state(button_state), .button_grounded(button_grounded),
    .locked(locked), .splash_show(splash_show), .script_run(script_run),
    .rx_frame_err(rx_frame_err));
  scl_host #(.BIT_CYC(BIT_CYC), .SETTLE_CYC(50)) u_scl_host (.sys_clk(sys_clk),
    .rst_n(rst_n), .link(u_scl_link_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_byte(cmd_byte), .cmd_last(cmd_last), .reply_valid(reply_valid),
    .reply_byte(reply_byte));
  scl_link_assertions #(.BIT_CYC(BIT_CYC)) u_scl_link_assertions (.sys_clk(sys_clk),
    .rst_n(rst_n), .host_to_dev(u_scl_link_if.host_to_dev),
    .dev_to_host(u_scl_link_if.dev_to_host), .reset_pull_oe(u_scl_link_if.reset_pull_oe),
    .reset_line_n(u_scl_link_if.reset_line_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Note a reply byte both for the user side and for the wire
  task automatic expect_byte(input logic [7:0] b);
    exp_q.push_back(b);
    wire_q.push_back(b);
  endtask
  task automatic wait_ready();
    int t;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (cmd_ready !== 1'b1 && t < 20000);
  endtask
  // One whole command byte, held until the host takes it
  task automatic send_byte(input logic [7:0] b, input logic last);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_byte = b;
    cmd_last = last;
    wait_ready();
    armed = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  // Replies still owed, both to the user side and on the wire
  task automatic wait_replies();
    while (exp_q.size() != 0 || wire_q.size() != 0) @(posedge sys_clk);
  endtask
  // One random command, known or unknown, replies noted before sending
  task automatic run_cmd(input logic last, input logic new_btn);
    logic [7:0] op;
    if (new_btn) begin
      btn_k = $urandom % 6;
      @(negedge sys_clk);
      button_state = (btn_k == 0) ? 5'h00 : 5'(5'h01 << (btn_k - 1));
    end
    case ($urandom % 4)
      0: op = `SCL_CMD_NOP;
      1: op = `SCL_CMD_FAIL;
      2: op = `SCL_CMD_BUTTONS;
      default: begin
        do op = 8'($urandom);
        while (op inside {`SCL_CMD_NOP, `SCL_CMD_FAIL, `SCL_CMD_BUTTONS, `SCL_BYTE_LOCK});
      end
    endcase
    case (op)
      `SCL_CMD_NOP: expect_byte(`SCL_BYTE_ACK);
      `SCL_CMD_BUTTONS: begin
        expect_byte(8'(btn_k));
        expect_byte(`SCL_BYTE_ACK);
      end
      default: expect_byte(`SCL_BYTE_NAK);
    endcase
    send_byte(op, last);
  endtask
  // Hang guard: the whole run needs some 20000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Oldest noted reply against each reply pulse; lock reply is not noted
  always @(posedge sys_clk) begin
    if (armed && reply_valid === 1'b1) begin
      check(reply_byte, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    end
  end
  // Decode device frames at mid-bit, independent of the host receiver
  initial begin : wire_watch
    logic [7:0] b;
    forever begin
      @(negedge u_scl_link_if.dev_to_host);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      check({7'h00, u_scl_link_if.dev_to_host}, 8'h00);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        b[i] = u_scl_link_if.dev_to_host;
      end
      repeat (BIT_CYC) @(posedge sys_clk);
      check({7'h00, u_scl_link_if.dev_to_host}, 8'h01);
      if (armed) check(b, wire_q.size() != 0 ? wire_q.pop_front() : 8'hxx);
    end
  end
  initial begin : main_seq
    void'($urandom(54));
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    wait_ready();
    check({7'h00, locked}, 8'h01);
    // Single commands, buttons changing each time, next only once all replies are in
    for (int n = 0; n < 16; n++) begin
      run_cmd(1'b1, 1'b1);
      wait_replies();
    end
    check({7'h00, splash_show}, 8'h00);
    check({7'h00, script_run}, 8'h00);
    check({7'h00, rx_frame_err}, 8'h00);
    // Second reset mid-run with the button input grounded; lock reply not noted
    armed = 1'b0;
    @(negedge sys_clk);
    button_grounded = 1'b1;
    rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    wait_ready();
    @(negedge sys_clk);
    button_grounded = 1'b0;
    check({7'h00, locked}, 8'h01);
    check({7'h00, script_run}, 8'h01);
    check({7'h00, splash_show}, 8'h00);
    // Burst without waiting, so bytes queue in the device buffer behind replies
    for (int n = 0; n < 8; n++) run_cmd(n == 7, 1'b0);
    wait_replies();
    check({7'h00, rx_frame_err}, 8'h00);
    wrap_up();
  end
endmodule
